//--- rtl/sfa_pkg.sv
/*
 Shared constants and types for the two-wire memory slave and its master.
 Assumes both ends run on one core clock of 10 MHz.
*/
package sfa_pkg;
	localparam int ADDR_W = 11;
	localparam int PAGE_W = 3;
	localparam int LOW_W = 8;
	// Device type nibble: arbitrary value
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam int TYPE_LO = 4;
	localparam int PAGE_HI = 3;
	localparam int PAGE_LO = 1;
	localparam int RW_BIT = 0;
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	// Bit counter marks within one byte frame
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] ACK_DONE = 4'h9;
	localparam logic [7:0] LEN_ONE = 8'h01;
	// Link clock made by the master: period in ns, four phases per bit
	localparam int CORE_PERIOD_NS = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam int QTR_CYC = LINK_PERIOD_NS / (4 * CORE_PERIOD_NS);
	localparam int QTR_MIN = 2;
	typedef enum logic [1:0] {
		SFA_OP_WRITE,
		SFA_OP_CUR_READ,
		SFA_OP_SEL_READ
	} sfa_op_t;
endpackage

//--- rtl/sfa_link_if.sv
/*
 Two-wire link between master and memory slave.
 Assumes open-drain wires with pull-ups; levels resolved here from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfa_link_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	wire logic scl;
	wire logic sda;
	assign scl = scl_m_oe ? scl_m_o : 1'b1;
	assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
	modport master (
		output scl_m_o,
		output scl_m_oe,
		output sda_m_o,
		output sda_m_oe,
		input scl,
		input sda
	);
	modport slave (
		output sda_s_o,
		output sda_s_oe,
		input scl,
		input sda
	);
endinterface // sfa_link_if
`default_nettype wire

//--- rtl/sfa_sync.sv
/*
 Two-flop synchroniser for pins entering the core clock domain.
 Assumes inputs are asynchronous levels; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module sfa_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '1;
			q <= '1;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // sfa_sync
`default_nettype wire

//--- rtl/sfa_dev.sv
/*
 Memory end of the two-wire link: 2K x 8 array with byte writes at bus speed.
 Assumes the master makes the link clock; wp is a pin, low when undriven.
*/
// Overview of operation
// - Write opens with direction-zero address, word address
// - Acknowledge every written byte while protect is low, unlimited count
// - Write address wraps from top to zero
// - No write cycle; busy only during a transfer; always acknowledges its address
// - Commit byte at eighth bit, before acknowledge
// - Start or stop mid-byte drops the write
// - No page buffer; each byte written directly
// - Protect input high refuses data bytes
// - Refused write leaves the address unchanged
// - Protect input low enables writes; defaults low
// - Read address is page plus latched low byte
// - Read data starts on clock after address
// - Current read continues after last accessed low byte, in the page of the address byte
// - Address increments per read byte, the nacked last byte included
// - Master ends reads with nack or condition
// - Read address wraps from top to zero
// - Word address byte loads the address latch
// - Repeated start after word address gives random read
// - Address byte: type, page, direction fields
// - Bytes move most significant bit first
// - Missing acknowledge aborts until addressed again
`timescale 1ns/1ps
`default_nettype none
module sfa_dev #(
	parameter int ADDR_W = sfa_pkg::ADDR_W,
	parameter logic [3:0] DEV_TYPE = sfa_pkg::DEV_TYPE
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wp,
	sfa_link_if.slave link,
	output logic [ADDR_W-1:0] cur_addr,
	output logic busy
);
	typedef enum logic [2:0] {
		SFA_D_IDLE,
		SFA_D_DEV,
		SFA_D_WORD,
		SFA_D_WR,
		SFA_D_RD
	} sfa_dst_t;

	if (ADDR_W != sfa_pkg::PAGE_W + sfa_pkg::LOW_W) begin : g_chk
		$error("sfa_dev: ADDR_W must equal page plus low byte width");
	end

	sfa_dst_t st_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] out_q;
	logic rw_q;
	logic oe_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] mem_q [0:(2**ADDR_W)-1];
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic scl_p_q;
	logic sda_p_q;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic last_rise;
	logic dev_ok;
	logic wr_ok;
	logic wr_commit;
	logic [7:0] byte_in;

	// Pins cross into the core domain before any decode
	sfa_sync #(.W(3)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.d({link.scl, link.sda, wp}),
		.q({scl_s, sda_s, wp_s})
	);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce) begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	always_comb begin
		rise = scl_s & ~scl_p_q;
		fall = ~scl_s & scl_p_q;
		start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
		stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
		byte_in = {sh_q[6:0], sda_s};
		last_rise = rise & (cnt_q == sfa_pkg::BIT_LAST);
		dev_ok = byte_in[7:sfa_pkg::TYPE_LO] == DEV_TYPE;
		// Undriven pin reads low, so writes are open by default
		wr_ok = ~wp_s;
		wr_commit = last_rise & (st_q == SFA_D_WR) & wr_ok;
	end

	// Transfer state and bit count
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SFA_D_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= sfa_pkg::RW_WRITE;
		end else if (ce) begin
			if (start_c) begin
				st_q <= SFA_D_DEV;
				cnt_q <= 4'h0;
			end else if (stop_c) begin
				st_q <= SFA_D_IDLE;
				cnt_q <= 4'h0;
			end else if (rise && st_q != SFA_D_IDLE) begin
				if (cnt_q < sfa_pkg::ACK_SLOT) begin
					sh_q <= byte_in;
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == sfa_pkg::BIT_LAST) begin
						case (st_q)
							SFA_D_DEV: begin
								rw_q <= byte_in[sfa_pkg::RW_BIT];
								if (!dev_ok) begin
									st_q <= SFA_D_IDLE;
								end
							end
							SFA_D_WR: begin
								if (!wr_ok) begin
									st_q <= SFA_D_IDLE;
								end
							end
							default: begin
							end
						endcase
					end
				end else begin
					cnt_q <= sfa_pkg::ACK_DONE;
					// Master nack ends the read; bus left free
					if (st_q == SFA_D_RD && sda_s) begin
						st_q <= SFA_D_IDLE;
					end
				end
			end else if (fall && cnt_q == sfa_pkg::ACK_DONE) begin
				cnt_q <= 4'h0;
				case (st_q)
					SFA_D_DEV: st_q <= (rw_q == sfa_pkg::RW_READ) ? SFA_D_RD : SFA_D_WORD;
					SFA_D_WORD: st_q <= SFA_D_WR;
					default: begin
					end
				endcase
			end
		end
	end

	// Address latch: page from address byte, low byte from word address
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= '0;
		end else if (ce && last_rise) begin
			case (st_q)
				SFA_D_DEV: begin
					if (dev_ok) begin
						addr_q[ADDR_W-1:sfa_pkg::LOW_W] <=
							byte_in[sfa_pkg::PAGE_HI:sfa_pkg::PAGE_LO];
					end
				end
				SFA_D_WORD: addr_q[sfa_pkg::LOW_W-1:0] <= byte_in;
				// Natural roll-over gives the top-to-zero wrap
				SFA_D_WR: begin
					if (wr_ok) begin
						addr_q <= addr_q + 1'b1;
					end
				end
				SFA_D_RD: addr_q <= addr_q + 1'b1;
				default: begin
				end
			endcase
		end
	end

	// Array written per byte; no staging, so no write delay exists
	always_ff @(posedge core_clk) begin
		if (ce && wr_commit) begin
			mem_q[addr_q] <= byte_in;
		end
	end

	// Slave drive on the data wire, changed while clock is low, or cleared at a start or stop
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			oe_q <= 1'b0;
			out_q <= 8'h00;
		end else if (ce) begin
			if (start_c || stop_c) begin
				oe_q <= 1'b0;
			end else if (fall) begin
				if (cnt_q == sfa_pkg::ACK_SLOT) begin
					// Ack only for states still alive; refused bytes went idle
					oe_q <= (st_q != SFA_D_RD) && (st_q != SFA_D_IDLE);
				end else if (cnt_q == sfa_pkg::ACK_DONE) begin
					if ((st_q == SFA_D_DEV && rw_q == sfa_pkg::RW_READ) || st_q == SFA_D_RD) begin
						out_q <= mem_q[addr_q];
						oe_q <= ~mem_q[addr_q][7];
					end else begin
						oe_q <= 1'b0;
					end
				end else if (st_q == SFA_D_RD) begin
					out_q <= {out_q[6:0], 1'b0};
					oe_q <= ~out_q[6];
				end
			end
		end
	end

	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = oe_q;
	assign cur_addr = addr_q;
	assign busy = st_q != SFA_D_IDLE;
endmodule // sfa_dev
`default_nettype wire

//--- rtl/sfa_host.sv
/*
 Master end of the two-wire link: makes the link clock by division and runs
 writes, current reads and selective reads. Assumes no clock stretching.
*/
`timescale 1ns/1ps
`default_nettype none
module sfa_host #(
	parameter int QTR = sfa_pkg::QTR_CYC,
	parameter logic [3:0] DEV_TYPE = sfa_pkg::DEV_TYPE
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	sfa_link_if.master link,
	input wire logic req_valid,
	output logic req_ready,
	input wire sfa_pkg::sfa_op_t req_op,
	input wire logic [2:0] req_page,
	input wire logic [7:0] req_word,
	input wire logic [7:0] req_len,
	input wire logic wd_valid,
	input wire logic [7:0] wd_data,
	output logic wd_ready,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic nack
);
	typedef enum logic [2:0] {
		SFA_H_IDLE,
		SFA_H_START,
		SFA_H_TX,
		SFA_H_RX,
		SFA_H_STOP
	} sfa_hst_t;
	typedef enum logic [1:0] {
		SFA_G_DEV,
		SFA_G_WORD,
		SFA_G_DATA
	} sfa_stage_t;

	// Slave needs about three cycles to react to a clock edge
	if (QTR < sfa_pkg::QTR_MIN) begin : g_chk
		$error("sfa_host: QTR too small for slave edge latency");
	end

	sfa_hst_t st_q;
	sfa_stage_t stg_q;
	sfa_pkg::sfa_op_t op_q;
	logic [$clog2(QTR+1)-1:0] qc_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [2:0] page_q;
	logic [7:0] word_q;
	logic [7:0] len_q;
	logic rdp_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic tick;
	logic sda_s;

	function automatic logic [7:0] dev_byte(input logic [2:0] pg, input logic rd);
		dev_byte = {DEV_TYPE, pg, rd};
	endfunction

	sfa_sync #(.W(1)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.d(link.sda),
		.q(sda_s)
	);

	assign tick = qc_q == ($clog2(QTR+1))'(QTR - 1);
	assign req_ready = st_q == SFA_H_IDLE;

	// Quarter-bit timebase for the divided link clock
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			qc_q <= '0;
			ph_q <= 2'h0;
		end else if (ce) begin
			if (st_q == SFA_H_IDLE) begin
				qc_q <= '0;
				ph_q <= 2'h0;
			end else if (tick) begin
				qc_q <= '0;
				ph_q <= ph_q + 2'h1;
			end else begin
				qc_q <= qc_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SFA_H_IDLE;
			stg_q <= SFA_G_DEV;
			op_q <= sfa_pkg::SFA_OP_WRITE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			page_q <= 3'h0;
			word_q <= 8'h00;
			len_q <= sfa_pkg::LEN_ONE;
			rdp_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			wd_ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			done <= 1'b0;
			nack <= 1'b0;
		end else if (ce) begin
			wd_ready <= 1'b0;
			rd_valid <= 1'b0;
			done <= 1'b0;
			case (st_q)
				SFA_H_IDLE: begin
					if (req_valid) begin
						op_q <= req_op;
						page_q <= req_page;
						word_q <= req_word;
						len_q <= (req_len == 8'h00) ? sfa_pkg::LEN_ONE : req_len;
						nack <= 1'b0;
						rdp_q <= 1'b0;
						stg_q <= SFA_G_DEV;
						st_q <= SFA_H_START;
					end
				end
				SFA_H_START: begin
					if (tick) begin
						case (ph_q)
							2'h0: sda_oe_q <= 1'b0;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b1;
							default: begin
								scl_oe_q <= 1'b1;
								bit_q <= 4'h0;
								sh_q <= dev_byte(page_q, (op_q == sfa_pkg::SFA_OP_CUR_READ) | rdp_q);
								st_q <= SFA_H_TX;
							end
						endcase
					end
				end
				SFA_H_TX, SFA_H_RX: begin
					if (tick) begin
						case (ph_q)
							2'h0: begin
								if (bit_q < sfa_pkg::ACK_SLOT) begin
									sda_oe_q <= (st_q == SFA_H_TX) ? ~sh_q[7] : 1'b0;
								end else begin
									// Last read byte gets a nack
									sda_oe_q <= (st_q == SFA_H_RX) && (len_q != sfa_pkg::LEN_ONE);
								end
							end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
							end
							default: begin
								scl_oe_q <= 1'b1;
								bit_q <= bit_q + 4'h1;
								if (bit_q < sfa_pkg::ACK_SLOT) begin
									sh_q <= (st_q == SFA_H_TX) ? {sh_q[6:0], 1'b0} : {sh_q[6:0], sda_s};
								end else if (st_q == SFA_H_RX) begin
									bit_q <= 4'h0;
									rd_data <= sh_q;
									rd_valid <= 1'b1;
									len_q <= len_q - 8'h01;
									st_q <= (len_q == sfa_pkg::LEN_ONE) ? SFA_H_STOP : SFA_H_RX;
								end else if (sda_s) begin
									nack <= 1'b1;
									st_q <= SFA_H_STOP;
								end else begin
									bit_q <= 4'h0;
									// Shifter is empty by now, so the direction comes from the request
									if (stg_q == SFA_G_DEV && ((op_q == sfa_pkg::SFA_OP_CUR_READ) || rdp_q)) begin
										stg_q <= SFA_G_DATA;
										st_q <= SFA_H_RX;
									end else if (stg_q == SFA_G_DEV) begin
										stg_q <= SFA_G_WORD;
										sh_q <= word_q;
									end else if (stg_q == SFA_G_WORD && op_q == sfa_pkg::SFA_OP_SEL_READ) begin
										rdp_q <= 1'b1;
										stg_q <= SFA_G_DEV;
										st_q <= SFA_H_START;
									end else if (wd_valid) begin
										stg_q <= SFA_G_DATA;
										sh_q <= wd_data;
										wd_ready <= 1'b1;
									end else begin
										// Stop only at byte boundaries so no write is cut
										st_q <= SFA_H_STOP;
									end
								end
							end
						endcase
					end
				end
				SFA_H_STOP: begin
					if (tick) begin
						case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							default: begin
								done <= 1'b1;
								st_q <= SFA_H_IDLE;
							end
						endcase
					end
				end
				default: st_q <= SFA_H_IDLE;
			endcase
		end
	end

	assign link.scl_m_o = 1'b0;
	assign link.scl_m_oe = scl_oe_q;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe = sda_oe_q;
endmodule // sfa_host
`default_nettype wire

//--- tb/sfa_link_assertions.sv
/*
 Checker on the two-wire link between the master and memory ends.
 Assumes the interface signals are handed in by name from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module sfa_link_assertions (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic scl_m_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q, sda_q, first_q, rw_q, live_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	wire logic rise = scl && !scl_q;
	// Start or stop: sda moves while scl stays high
	wire logic cond = scl && scl_q && (sda != sda_q);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// Frame tracking; a nack ends the frame so stop clocks are not data
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 4'h0;
			first_q <= 1'b1;
			rw_q <= 1'b0;
			live_q <= 1'b0;
			sh_q <= 8'h00;
		end else if (cond) begin
			cnt_q <= 4'h0;
			first_q <= 1'b1;
			live_q <= !sda;
		end else if (rise) begin
			sh_q <= {sh_q[6:0], sda};
			cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			if (cnt_q == 4'h8) first_q <= 1'b0;
			if (cnt_q == 4'h8 && sda) live_q <= 1'b0;
			if (first_q && cnt_q == 4'h7) rw_q <= sda;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_addr_ack: assert property (
		rise && first_q && cnt_q == 4'h8 && sh_q[7:4] == sfa_pkg::DEV_TYPE |-> !sda)
		else $error("address byte not acknowledged");
	a_read_release: assert property (
		rise && !first_q && rw_q && cnt_q == 4'h8 |-> !sda_s_oe)
		else $error("slave drives the master ack slot");
	a_read_drive: assert property (
		rise && live_q && !first_q && rw_q && cnt_q < 4'h8 |-> !sda_m_oe && (sda == !sda_s_oe))
		else $error("read bit not driven by slave");
	a_write_quiet: assert property (
		rise && live_q && !first_q && !rw_q && cnt_q < 4'h8 |-> !sda_s_oe)
		else $error("slave drives while master sends");
	a_oe_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("slave sda moved while scl high");
	a_sda_stable: assert property (cond |-> $changed(sda_m_oe))
		else $error("sda moved under high scl without master");
	a_nack_quiet: assert property (
		rise && cnt_q == 4'h8 && sda |=> !sda_s_oe [*8])
		else $error("slave drives after a nack");
	a_ack_hold: assert property ($rose(sda_s_oe) |-> sda_s_oe [*4])
		else $error("slave drive too short");
	a_reset_idle: assert property ($rose(nrst) |-> scl && sda && !sda_s_oe)
		else $error("link not idle after reset");
	a_master_sda: assert property (
		$changed(sda_m_oe) |-> $past(scl_m_oe) || cond)
		else $error("master sda moved under high scl outside a condition");
	c_read_ack: cover property (rise && !first_q && rw_q && cnt_q == 4'h8 && !sda);
	c_write_nack: cover property (rise && !first_q && !rw_q && cnt_q == 4'h8 && sda);
	c_rep_start: cover property (cond && !sda && !first_q);
endmodule // sfa_link_assertions
`default_nettype wire

//--- tb/tb_top.sv
/*
 Bench joining the master and memory ends over one link.
 Assumes the master makes the link clock from core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0, nrst = 1'b0, wp = 1'b0, req_valid = 1'b0, wd_valid = 1'b0;
	sfa_pkg::sfa_op_t req_op = sfa_pkg::SFA_OP_WRITE;
	logic [2:0] req_page = 3'h0;
	logic [7:0] req_word = 8'h00, req_len = 8'h00, wd_data = 8'h00, rd_data;
	logic req_ready, wd_ready, rd_valid, done, nack, busy;
	logic [10:0] cur_addr, exp_a;
	logic [7:0] mem [2048];
	logic [7:0] exp_q [$];
	int bad_count = 0, n_checks = 0;
	always #50 core_clk = ~core_clk;
	sfa_link_if sfa_link_if_i ();
	sfa_host sfa_host_i (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .link(sfa_link_if_i),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_page(req_page),
		.req_word(req_word), .req_len(req_len), .wd_valid(wd_valid), .wd_data(wd_data),
		.wd_ready(wd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
	sfa_dev sfa_dev_i (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .wp(wp),
		.link(sfa_link_if_i), .cur_addr(cur_addr), .busy(busy));
	sfa_link_assertions sfa_link_assertions_i (.core_clk(core_clk), .nrst(nrst),
		.scl_m_oe(sfa_link_if_i.scl_m_oe), .sda_m_oe(sfa_link_if_i.sda_m_oe),
		.sda_s_oe(sfa_link_if_i.sda_s_oe), .scl(sfa_link_if_i.scl), .sda(sfa_link_if_i.sda));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One request; ok low means the data byte is expected to be refused
	task automatic run(input sfa_pkg::sfa_op_t op, input logic [2:0] pg, input logic [7:0] wo,
		input int n, input logic ok);
		logic [7:0] d [$];
		int i;
		exp_a = (op == sfa_pkg::SFA_OP_CUR_READ) ? {pg, exp_a[7:0]} : {pg, wo};
		for (i = 0; i < n; i++) begin
			d.push_back(8'($urandom));
			if (op == sfa_pkg::SFA_OP_WRITE) begin
				if (ok) begin
					mem[exp_a] = d[i];
					exp_a++;
				end
			end else begin
				exp_q.push_back(mem[exp_a]);
				exp_a++;
			end
		end
		@(negedge core_clk);
		req_valid = 1'b1;
		req_op = op;
		req_page = pg;
		req_word = wo;
		req_len = 8'(n);
		wd_valid = (op == sfa_pkg::SFA_OP_WRITE);
		wd_data = d[0];
		@(posedge core_clk iff req_ready);
		@(negedge core_clk);
		req_valid = 1'b0;
		if (op == sfa_pkg::SFA_OP_WRITE) begin
			for (i = 1; i <= n; i++) begin
				@(posedge core_clk iff wd_ready);
				chk("busy_mid", 16'(busy), 16'h0001);
				@(negedge core_clk);
				if (i < n) wd_data = d[i];
				else wd_valid = 1'b0;
			end
		end
		@(posedge core_clk iff done);
		chk("nack", 16'(nack), 16'(!ok));
		#1;
		chk("cur_addr", 16'(cur_addr), 16'(exp_a));
		chk("busy_end", 16'(busy), 16'h0000);
	endtask
	// Read scoreboard: oldest note against each byte delivered
	initial forever begin
		@(posedge core_clk iff rd_valid === 1'b1);
		if (exp_q.size() == 0) chk("rd_extra", 16'h0001, 16'h0000);
		else chk("rd_data", 16'(rd_data), 16'(exp_q.pop_front()));
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		final_report();
	end
	initial begin
		void'($urandom(32'h3550F4F1));
		exp_a = 11'h000;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		// Back to back, crossing the top of the array
		run(sfa_pkg::SFA_OP_WRITE, 3'h7, 8'hFE, 6, 1'b1);
		run(sfa_pkg::SFA_OP_SEL_READ, 3'h7, 8'hFE, 4, 1'b1);
		run(sfa_pkg::SFA_OP_CUR_READ, 3'h0, 8'h00, 2, 1'b1);
		run(sfa_pkg::SFA_OP_WRITE, 3'h5, 8'h04, 1, 1'b1);
		run(sfa_pkg::SFA_OP_SEL_READ, 3'h0, 8'h03, 1, 1'b1);
		run(sfa_pkg::SFA_OP_CUR_READ, 3'h5, 8'h00, 1, 1'b1);
		@(negedge core_clk);
		wp = 1'b1;
		run(sfa_pkg::SFA_OP_WRITE, 3'h0, 8'h00, 1, 1'b0);
		@(negedge core_clk);
		wp = 1'b0;
		run(sfa_pkg::SFA_OP_CUR_READ, 3'h0, 8'h00, 1, 1'b1);
		chk("rd_left", 16'(exp_q.size()), 16'h0000);
		final_report();
	end
endmodule // tb_top
`default_nettype wire
